// ---- bench/motor_measurement_readback_monitor.sv ----
// Checker of the bank's bus answers
`timescale 1ns/100ps
`default_nettype none
module motor_measurement_readback_monitor (
   input wire logic        clk,       // Clock
   input wire logic        rst,       // Reset
   input wire logic        wb_cyc_i,  // Cycle
   input wire logic        wb_stb_i,  // Strobe
   input wire logic        wb_we_i,   // Write
   input wire logic [13:0] wb_adr_i,  // Address
   input wire logic [31:0] wb_dat_o,  // Read data
   input wire logic        wb_ack_o,  // Ack
   input wire logic        speedLoad, // Speed load
   input wire logic [31:0] speedValue // Speed word
);
   wire logic req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_speed; speedLoad ##1 (req && !wb_we_i && !speedLoad &&
      wb_adr_i == 14'h0658) |=> wb_dat_o == $past(speedValue, 2); endproperty
   a_speed: assert property (p_speed) else $error("speed word");
   property p_wr; req && wb_we_i |=> wb_ack_o && wb_dat_o == 32'h0;
   endproperty
   a_wr: assert property (p_wr) else $error("write answer");
   property p_ans; req |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ans: assert property (p_ans) else $error("ack pulse");
   property p_lone; wb_ack_o |-> $past(req); endproperty
   a_lone: assert property (p_lone) else $error("stray ack");
   property p_hole; req && wb_adr_i == 14'h0004 |=> wb_dat_o == 32'h0;
   endproperty
   a_hole: assert property (p_hole) else $error("unmapped data");
   property p_rst; $fell(rst) |-> !wb_ack_o && wb_dat_o == 32'h0; endproperty
   a_rst: assert property (p_rst) else $error("reset value");
   property p_hold; !$past(req) |-> $stable(wb_dat_o); endproperty
   a_hold: assert property (p_hold) else $error("data moved");
   property p_gain; req && !wb_we_i && wb_adr_i == 14'h11A0 |=>
      wb_dat_o[31:16] == 16'h0000; endproperty
   a_gain: assert property (p_gain) else $error("gain upper bits");
   c_wr: cover property (req && wb_we_i);
   c_speed: cover property (speedLoad ##1 req);
   c_hole: cover property (req && wb_adr_i == 14'h0004);
endmodule
bind motor_measurement_readback motor_measurement_readback_monitor
   motor_measurement_readback_monitor_inst (.*);
`default_nettype wire

// ---- bench/tb_motor_measurement_readback.sv ----
// Bench for the measurement bank
`timescale 1ns/100ps
`default_nettype none
module tb_motor_measurement_readback;
   localparam logic [13:0] ADR [6] = '{14'h0658, 14'h1040, 14'h1100,
      14'h1108, 14'h1110, 14'h11A0};
   logic        clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, speedLoad;
   logic        supplyLoad, windALoad, windBLoad, windCLoad, gainLoad;
   logic [3:0]  wb_sel_i;
   logic [5:0]  lds;
   logic [13:0] wb_adr_i;
   logic [15:0] gainValue;
   logic [31:0] wb_dat_i, wb_dat_o, speedValue, supplyValue, windAValue;
   logic [31:0] windBValue, windCValue, val, exp [6];
   int          errors, nChecks, cycles;
   assign {speedLoad, supplyLoad, windALoad, windBLoad, windCLoad,
      gainLoad} = lds;
   assign {speedValue, supplyValue, windAValue, windBValue, windCValue,
      gainValue} = {val, val, val, val, val, val[15:0]};
   motor_measurement_readback motor_measurement_readback_inst (.*);
   task automatic end_of_test(input int extra);
      errors += extra;
      $display("checks %0d errors %0d", nChecks, errors);
      if (errors == 0 && nChecks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check_word(input logic [13:0] a, logic [31:0] e, s);
      nChecks++;
      if (s !== e)
      begin
         errors++;
         $display("wrong value wb_dat_o at %h expected %h seen %h", a, e, s);
      end
   endtask
   // Ack must be gone one cycle after it was given
   task automatic check_ack(input logic s);
      nChecks++;
      if (s !== 1'h0)
      begin
         errors++;
         $display("wrong value wb_ack_o expected 0 seen %b", s);
      end
   endtask
   task automatic acc(input logic w, logic [13:0] a, logic [31:0] e);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i} <= {2'h3, w, a};
      wb_dat_i <= {a, a, 4'hF};
      @(posedge clk);
      while (wb_ack_o !== 1'h1)
         @(posedge clk);
      check_word(a, e, wb_dat_o);
      {wb_cyc_i, wb_stb_i} <= 2'h0;
      @(posedge clk);
      check_ack(wb_ack_o);
   endtask
   // Pulse one load, then read the word back at once
   task automatic load(input int i, logic [31:0] v);
      lds <= 6'h20 >> i;
      val <= v;
      exp[i] = v;
      @(posedge clk);
      lds <= 6'h00;
      acc(1'h0, ADR[i], v);
   endtask
   task automatic t_words;
      for (int i = 0; i < 6; i++)
         acc(1'h0, ADR[i], 32'h0);
      for (int i = 0; i < 5; i++)
         load(i, 32'h9C3A_5E71 << i);
      for (int c = 0; c < 4; c++)
         load(5, 32'(c));
   endtask
   task automatic t_write;
      for (int i = 0; i < 6; i++)
      begin
         acc(1'h1, ADR[i], 32'h0);
         acc(1'h0, ADR[i], exp[i]);
      end
      acc(1'h0, 14'h065A, 32'h0);
      acc(1'h0, ADR[0], exp[0]);
      acc(1'h0, 14'h0004, 32'h0);
   endtask
   // Mid-run reset clears every loaded word
   task automatic t_reset;
      rst <= 1'h1;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      for (int i = 0; i < 6; i++)
         acc(1'h0, ADR[i], 32'h0);
   endtask
   initial
   begin
      clk = 1'h0;
      forever #20 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 2000)
         end_of_test(1);
   end
   initial
   begin
      {rst, wb_sel_i} = 5'h1F;
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, lds, val} = '0;
      repeat (2) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      t_words();
      t_write();
      t_reset();
      end_of_test(0);
   end
endmodule
`default_nettype wire

// ---- rtl/meas_if.sv ----
// Interface carrying one capture request and the captured word
`timescale 1ns/100ps
`default_nettype none
interface meas_if;
   logic        load;
   logic [31:0] value;
   logic [31:0] held;
   modport owner (input load, input value, output held);
   modport user  (output load, output value, input held);
endinterface
`default_nettype wire

// ---- rtl/meas_pkg.sv ----
// Package of register map, widths and reset values for the measurement bank
// What this block does
// - Read-only 32-bit rotor speed estimate, Q27 scaled
// - Read-only 32-bit supply current, Q27 over eight
// - Read-only 32-bit winding A current, Q27
// - Read-only 32-bit winding B current, Q27
// - Read-only 32-bit winding C current, Q27
// - Read-only 16-bit gain code, 0..3 encoded
package meas_pkg;
   localparam int          DATA_W        = 32;
   localparam int          GAIN_W        = 16;
   localparam int          ADDR_W        = 14;
   localparam int          IDX_W         = 12;
   localparam int          NUM_REGS      = 6;
   localparam int          FRAC_BITS     = 27;
   localparam int          CURRENT_DIV   = 8;
   localparam logic [11:0] IDX_SPEED     = 12'h196;
   localparam logic [11:0] IDX_SUPPLY    = 12'h410;
   localparam logic [11:0] IDX_WIND_A    = 12'h440;
   localparam logic [11:0] IDX_WIND_B    = 12'h442;
   localparam logic [11:0] IDX_WIND_C    = 12'h444;
   localparam logic [11:0] IDX_GAIN      = 12'h468;
   localparam logic [31:0] RESET_VALUE   = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
   localparam logic [15:0] GAIN_X8       = 16'h0000;
   localparam logic [15:0] GAIN_X4       = 16'h0001;
   localparam logic [15:0] GAIN_X2       = 16'h0002;
   localparam logic [15:0] GAIN_X1       = 16'h0003;
   localparam logic [2:0]  SEL_SPEED     = 3'h0;
   localparam logic [2:0]  SEL_SUPPLY    = 3'h1;
   localparam logic [2:0]  SEL_WIND_A    = 3'h2;
   localparam logic [2:0]  SEL_WIND_B    = 3'h3;
   localparam logic [2:0]  SEL_WIND_C    = 3'h4;
   localparam logic [2:0]  SEL_GAIN      = 3'h5;
   localparam logic [2:0]  SEL_NONE      = 3'h7;
endpackage

// ---- rtl/meas_word.sv ----
// One measurement word register, loaded only by the algorithm
`timescale 1ns/100ps
`default_nettype none
module meas_word #(
   parameter int          WIDTH = 32
) (
   input  wire logic      clk,   // System clock
   input  wire logic      rst,   // Synchronous reset, high
   meas_if.owner          port   // Load strobe, value, held word
);
   typedef struct packed {
      logic [WIDTH-1:0] word;
   } state_type;

   state_type s_q;
   state_type s_d;

   always_comb
   begin
      s_d = s_q;
      if (port.load)
      begin
         s_d.word = port.value[WIDTH-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   if (WIDTH < 32)
   begin : g_pad
      assign port.held = {{(32-WIDTH){1'b0}}, s_q.word};
   end
   else
   begin : g_full
      assign port.held = s_q.word;
   end
endmodule
`default_nettype wire

// ---- rtl/motor_measurement_readback.sv ----
// Wishbone classic read-only bank of motor measurement values
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module motor_measurement_readback (
   input  wire logic        clk,            // System clock, 25 MHz
   input  wire logic        rst,            // Synchronous reset, high
   input  wire logic        wb_cyc_i,       // Bus cycle
   input  wire logic        wb_stb_i,       // Strobe
   input  wire logic        wb_we_i,        // Write enable
   input  wire logic [13:0] wb_adr_i,       // Byte address
   input  wire logic [3:0]  wb_sel_i,       // Byte enables
   input  wire logic [31:0] wb_dat_i,       // Write data, discarded
   output logic      [31:0] wb_dat_o,       // Read data
   output logic             wb_ack_o,       // Acknowledge
   input  wire logic        speedLoad,      // Algorithm speed update
   input  wire logic [31:0] speedValue,     // New speed estimate
   input  wire logic        supplyLoad,     // Algorithm supply update
   input  wire logic [31:0] supplyValue,    // New supply current
   input  wire logic        windALoad,      // Winding A update
   input  wire logic [31:0] windAValue,     // New winding A current
   input  wire logic        windBLoad,      // Winding B update
   input  wire logic [31:0] windBValue,     // New winding B current
   input  wire logic        windCLoad,      // Winding C update
   input  wire logic [31:0] windCValue,     // New winding C current
   input  wire logic        gainLoad,       // Gain code update
   input  wire logic [15:0] gainValue       // New gain code
);
   typedef struct packed {
      logic        ack;
      logic [31:0] rdata;
   } state_type;

   state_type s_q;
   state_type s_d;

   meas_if speedIf ();
   meas_if supplyIf ();
   meas_if windAIf ();
   meas_if windBIf ();
   meas_if windCIf ();
   meas_if gainIf ();

   // Only the algorithm side drives the load strobes
   assign speedIf.load   = speedLoad;
   assign speedIf.value  = speedValue;
   assign supplyIf.load  = supplyLoad;
   assign supplyIf.value = supplyValue;
   assign windAIf.load   = windALoad;
   assign windAIf.value  = windAValue;
   assign windBIf.load   = windBLoad;
   assign windBIf.value  = windBValue;
   assign windCIf.load   = windCLoad;
   assign windCIf.value  = windCValue;
   assign gainIf.load    = gainLoad;
   assign gainIf.value   = {16'h0000, gainValue};

   meas_word #(.WIDTH(meas_pkg::DATA_W)) u_speed (
      .clk  (clk),
      .rst  (rst),
      .port (speedIf)
   );
   meas_word #(.WIDTH(meas_pkg::DATA_W)) u_supply (
      .clk  (clk),
      .rst  (rst),
      .port (supplyIf)
   );
   meas_word #(.WIDTH(meas_pkg::DATA_W)) u_wind_a (
      .clk  (clk),
      .rst  (rst),
      .port (windAIf)
   );
   meas_word #(.WIDTH(meas_pkg::DATA_W)) u_wind_b (
      .clk  (clk),
      .rst  (rst),
      .port (windBIf)
   );
   meas_word #(.WIDTH(meas_pkg::DATA_W)) u_wind_c (
      .clk  (clk),
      .rst  (rst),
      .port (windCIf)
   );
   meas_word #(.WIDTH(meas_pkg::GAIN_W)) u_gain (
      .clk  (clk),
      .rst  (rst),
      .port (gainIf)
   );

   logic        request;
   logic        aligned;
   logic [11:0] regIdx;
   logic [2:0]  regSel;

   assign request = wb_cyc_i & wb_stb_i & ~s_q.ack;
   assign aligned = (wb_adr_i[1:0] == 2'h0);
   assign regIdx  = wb_adr_i[13:2];

   // Index decode; byte address is four times the printed offset
   always_comb
   begin
      regSel = meas_pkg::SEL_NONE;
      if (aligned)
      begin
         case (regIdx)
            meas_pkg::IDX_SPEED:  regSel = meas_pkg::SEL_SPEED;
            meas_pkg::IDX_SUPPLY: regSel = meas_pkg::SEL_SUPPLY;
            meas_pkg::IDX_WIND_A: regSel = meas_pkg::SEL_WIND_A;
            meas_pkg::IDX_WIND_B: regSel = meas_pkg::SEL_WIND_B;
            meas_pkg::IDX_WIND_C: regSel = meas_pkg::SEL_WIND_C;
            meas_pkg::IDX_GAIN:   regSel = meas_pkg::SEL_GAIN;
            default:              regSel = meas_pkg::SEL_NONE;
         endcase
      end
   end

   always_comb
   begin
      s_d     = s_q;
      s_d.ack = 1'b0;
      if (request)
      begin
         s_d.ack = 1'b1;
         // Writes are acknowledged with zero read data but change no measurement word
         if (wb_we_i)
         begin
            s_d.rdata = meas_pkg::UNMAPPED_DATA;
         end
         else
         begin
            case (regSel)
               meas_pkg::SEL_SPEED:  s_d.rdata = speedIf.held;
               meas_pkg::SEL_SUPPLY: s_d.rdata = supplyIf.held;
               meas_pkg::SEL_WIND_A: s_d.rdata = windAIf.held;
               meas_pkg::SEL_WIND_B: s_d.rdata = windBIf.held;
               meas_pkg::SEL_WIND_C: s_d.rdata = windCIf.held;
               meas_pkg::SEL_GAIN:   s_d.rdata = gainIf.held;
               default:              s_d.rdata = meas_pkg::UNMAPPED_DATA;
            endcase
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign wb_dat_o = s_q.rdata;
   assign wb_ack_o = s_q.ack;
endmodule
`default_nettype wire
